// >>> psp_poll_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the poller
// Assumes: included by bare name from the poller and the bench
// Notes: definitions only
`ifndef PSP_POLL_MAP_SVH
`define PSP_POLL_MAP_SVH
// register offsets
`define PSP_OFF_CTL0 8'h88
`define PSP_OFF_CTL1 8'h8A
`define PSP_OFF_CTL2 8'h8C
`define PSP_OFF_RES5 8'hB2
// reset values and write masks
`define PSP_CTL0_RST 16'h8100
`define PSP_CTL_RST 16'h0000
`define PSP_CTL0_FIXED 16'h8100
`define PSP_CTL0_WMASK 16'h001F
`define PSP_CTL12_WMASK 16'h9F7F
// field positions
`define PSP_EN_BIT 15
`define PSP_REG_HI 12
`define PSP_REG_LO 8
`define PSP_PRE_BIT 6
`define PSP_DFLT_BIT 5
`define PSP_PHY_HI 4
`define PSP_PHY_LO 0
`define PSP_LEG_HI 9
`define PSP_LEG_LO 5
`define PSP_STATUS_REG 5'h01
// slot cursor codes
`define PSP_SLOT0 2'h0
`define PSP_SLOT1 2'h1
`define PSP_SLOT2 2'h2
`define PSP_SLOT5 2'h3
// frame fields and cell counts (count down to zero)
`define PSP_FRM_START 2'h1
`define PSP_FRM_READ 2'h2
`define PSP_PRE_CNT 5'h1F
`define PSP_CMD_CNT 5'h0D
`define PSP_TA_CNT 5'h01
`define PSP_DATA_CNT 5'h0F
// management clock timing
`define PSP_CLK_NS 100
`define PSP_MDC_HALF_NS 400
`define PSP_MDC_HALF_CYC ((`PSP_MDC_HALF_NS + `PSP_CLK_NS - 1) / `PSP_CLK_NS)
`endif

// >>> psp_pkg.sv
// Purpose: types shared by the poller and its bench
// Assumes: nothing
// Notes: numbers live in psp_poll_map.svh
package psp_pkg;
  // decoded slot control fields
  typedef struct packed {
    logic en;
    logic [4:0] regNum;
    logic preSup;
    logic useDflt;
    logic [4:0] phyAddr;
  } psp_slot_cfg_t;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] data;
  } psp_reg_req_t;
  // eeprom load beat
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [15:0] data;
  } psp_ee_wr_t;
  // management frame states
  typedef enum logic [2:0] {
    PSP_IDLE = 3'b000,
    PSP_PRE = 3'b001,
    PSP_CMD = 3'b010,
    PSP_TA = 3'b011,
    PSP_DATA = 3'b100
  } psp_state_t;
endpackage

// >>> psp_poller.sv
// Purpose: phy status poller with control and result registers
// Assumes: 10 MHz core_clk, mdio pin sampled through three flops
// Notes: slots 0, 1, 2 and 5 polled round robin over the management link
// Function
// RL1 - reset pin clears slot 5 result
// RL2 - eeprom start or error keeps slot 5 result
// RL3 - slot 5 result holds latest polled value
// RL4 - control registers default on reset and eeprom
// RL5 - slot 0 default enable one, register 00001
// RL6 - eeprom slot 0 load copies legacy address bits
// RL7 - slot 0 enable reads one always
// RL8 - slot 0 register number reads 00001 always
// RL9 - slot 0 holds the default phy address
// RL10 - host writes reserved bits as zero
// RL11 - slot 1 change sets its change flag
// RL12 - slot 1 register number, needs both enables
// RL13 - slot 1 bit 6 drops preamble
// RL14 - use-default bit selects default address
// RL15 - default phy preamble drop needs phy consent
// RL16 - slot 1 phy address from bits 4-0
// RL17 - slots 1 and 2 reset to zero
// RL18 - slot 2 change sets its change flag
// RL19 - clause 22 read frames, slots in turn
// RL20 - global enable off stops slots 1-5
`include "psp_poll_map.svh"
`timescale 1ns/1ps
`default_nettype none
module psp_poller #(
  parameter int POLL_GAP = 1000
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire psp_pkg::psp_reg_req_t regReq,
  output logic [15:0] regRdata,
  output logic regRvalid,
  input wire logic eeStart,
  input wire logic eeFail,
  input wire psp_pkg::psp_ee_wr_t eeWr,
  output logic [4:0] legacyPhyAddr,
  input wire logic globalPhyPollEnable,
  input wire logic defaultPhyNoPreamble,
  input wire logic slot5PollEnable,
  input wire logic [4:0] polledPhyRegisterSlot5,
  input wire logic [1:0] changeFlagClear,
  output logic slot1ChangeFlag,
  output logic slot2ChangeFlag,
  output logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe
);

  // decode of a slot control word
  function automatic psp_pkg::psp_slot_cfg_t cfgOf(input logic [15:0] w);
    psp_pkg::psp_slot_cfg_t c;
    c.en = w[`PSP_EN_BIT];
    c.regNum = w[`PSP_REG_HI:`PSP_REG_LO];
    c.preSup = w[`PSP_PRE_BIT];
    c.useDflt = w[`PSP_DFLT_BIT];
    c.phyAddr = w[`PSP_PHY_HI:`PSP_PHY_LO];
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] pollControlSlot0; // slot 0 control word
  logic [15:0] pollControlSlot1; // slot 1 control word
  logic [15:0] pollControlSlot2; // slot 2 control word
  logic [15:0] pollResultSlot5; // slot 5 result
  logic [15:0] lastValue [2]; // last value of slots 1 and 2
  logic [15:0] slot0View; // slot 0 as read
  logic [4:0] defaultPhyAddress; // default phy address
  logic ctlDefault; // control registers go to defaults

  assign ctlDefault = eeStart | eeFail;
  assign defaultPhyAddress = pollControlSlot0[`PSP_PHY_HI:`PSP_PHY_LO];
  // RL7 RL8 fixed fields
  assign slot0View = (pollControlSlot0 & `PSP_CTL0_WMASK) | `PSP_CTL0_FIXED;

  // control registers: defaults, eeprom load, host write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      // RL4 RL5 RL17 reset defaults
      pollControlSlot0 <= `PSP_CTL0_RST;
      pollControlSlot1 <= `PSP_CTL_RST;
      pollControlSlot2 <= `PSP_CTL_RST;
    end else if (ctlDefault) begin
      // RL4 eeprom defaults
      pollControlSlot0 <= `PSP_CTL0_RST;
      pollControlSlot1 <= `PSP_CTL_RST;
      pollControlSlot2 <= `PSP_CTL_RST;
    end else if (eeWr.valid) begin
      // eeprom data goes in masked like host data
      if (eeWr.addr == `PSP_OFF_CTL0) begin
        pollControlSlot0 <= (eeWr.data & `PSP_CTL0_WMASK) | `PSP_CTL0_FIXED;
      end
      if (eeWr.addr == `PSP_OFF_CTL1) begin
        pollControlSlot1 <= eeWr.data & `PSP_CTL12_WMASK;
      end
      if (eeWr.addr == `PSP_OFF_CTL2) begin
        pollControlSlot2 <= eeWr.data & `PSP_CTL12_WMASK;
      end
    end else if (regReq.wr) begin
      // RL9 RL10 only documented bits store
      if (regReq.addr == `PSP_OFF_CTL0) begin
        pollControlSlot0 <= (regReq.data & `PSP_CTL0_WMASK) | `PSP_CTL0_FIXED;
      end
      if (regReq.addr == `PSP_OFF_CTL1) begin
        pollControlSlot1 <= regReq.data & `PSP_CTL12_WMASK;
      end
      if (regReq.addr == `PSP_OFF_CTL2) begin
        pollControlSlot2 <= regReq.data & `PSP_CTL12_WMASK;
      end
    end
  end

  // legacy phy address copy
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      legacyPhyAddr <= 5'h00;
    end else if (eeWr.valid && !ctlDefault && eeWr.addr == `PSP_OFF_CTL0) begin
      // RL6 legacy address copy
      legacyPhyAddr <= eeWr.data[`PSP_LEG_HI:`PSP_LEG_LO];
    end
  end

  // read port: one cycle latency, unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 16'h0000;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regReq.rd;
      unique case (regReq.addr)
        `PSP_OFF_CTL0: regRdata <= slot0View;
        `PSP_OFF_CTL1: regRdata <= pollControlSlot1;
        `PSP_OFF_CTL2: regRdata <= pollControlSlot2;
        `PSP_OFF_RES5: regRdata <= pollResultSlot5;
        default: regRdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // management clock divider and mdio input sync
  logic [2:0] divCnt; // half period counter
  logic fallTick; // mdc about to fall
  logic mdcTick; // mdc edge enable
  logic [2:0] mdioSync; // three flop sync
  logic mdioVal; // filtered mdio level

  assign mdcTick = (divCnt == 3'(`PSP_MDC_HALF_CYC - 1));
  assign fallTick = mdcTick & mdc;

  // free running mdc
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt <= 3'h0;
      mdc <= 1'b0;
    end else if (mdcTick) begin
      divCnt <= 3'h0;
      mdc <= ~mdc;
    end else begin
      divCnt <= divCnt + 3'h1;
    end
  end

  // mdio sampled: changes when second and third flops agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mdioSync <= 3'h7;
      mdioVal <= 1'b1;
    end else begin
      mdioSync <= {mdioSync[1:0], mdioIn};
      if (mdioSync[1] == mdioSync[2]) begin
        mdioVal <= mdioSync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // slot scheduler
  psp_pkg::psp_slot_cfg_t cfg [4]; // per slot config
  logic [3:0] slotOn; // slot may be polled
  logic [1:0] curSlot; // slot of current frame
  logic [1:0] nextSlot; // next enabled slot
  logic [15:0] gapCnt; // spacing between frames
  logic frameStart; // frame begins this cycle
  logic usePre; // send preamble for next slot
  logic [4:0] tgtPhy; // phy address of next frame
  psp_pkg::psp_state_t state; // frame state

  always_comb begin
    cfg[0] = cfgOf(slot0View);
    cfg[0].useDflt = 1'b1;
    cfg[1] = cfgOf(pollControlSlot1);
    cfg[2] = cfgOf(pollControlSlot2);
    cfg[3] = '{en: slot5PollEnable, regNum: polledPhyRegisterSlot5,
      preSup: 1'b0, useDflt: 1'b1, phyAddr: 5'h00};
  end

  // RL12 RL18 RL20 enables gated by the global bit, slot 0 always eligible
  assign slotOn = {cfg[3].en & globalPhyPollEnable, cfg[2].en & globalPhyPollEnable,
    cfg[1].en & globalPhyPollEnable, 1'b1};

  // RL19 round robin pick after the current slot
  always_comb begin
    nextSlot = `PSP_SLOT0;
    for (int k = 3; k >= 1; k--) begin
      if (slotOn[2'(curSlot + 2'(k))]) begin
        nextSlot = 2'(curSlot + 2'(k));
      end
    end
  end

  // RL14 RL16 address and RL13 RL15 preamble choice
  assign tgtPhy = cfg[nextSlot].useDflt ? defaultPhyAddress : cfg[nextSlot].phyAddr;
  assign usePre = cfg[nextSlot].useDflt ? !defaultPhyNoPreamble : !cfg[nextSlot].preSup;
  assign frameStart = fallTick && state == psp_pkg::PSP_IDLE && gapCnt == 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // management read frame
  logic [4:0] bitCnt; // cells left in state
  logic [13:0] hdr; // start, opcode, phy, register
  logic [15:0] rxShift; // incoming data
  logic doneValid; // frame finished pulse
  logic riseTick; // mdc about to rise
  logic sampleDue; // data cell waits for its sample
  logic [13:0] frameHdr; // full header of the next frame

  assign riseTick = mdcTick & ~mdc;
  assign frameHdr = {`PSP_FRM_START, `PSP_FRM_READ, tgtPhy, cfg[nextSlot].regNum};

  // RL19 clause 22 read frame
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= psp_pkg::PSP_IDLE;
      bitCnt <= 5'h00;
      hdr <= 14'h0000;
      rxShift <= 16'h0000;
      curSlot <= `PSP_SLOT0;
      mdioOut <= 1'b1;
      mdioOe <= 1'b0;
      doneValid <= 1'b0;
      sampleDue <= 1'b0;
      gapCnt <= 16'(POLL_GAP);
    end else begin
      doneValid <= 1'b0;
      if (state == psp_pkg::PSP_IDLE && gapCnt != 16'h0000) begin
        gapCnt <= gapCnt - 16'h0001;
      end
      if (fallTick) begin
        unique case (state)
          psp_pkg::PSP_IDLE: begin
            if (frameStart) begin
              curSlot <= nextSlot;
              mdioOe <= 1'b1;
              if (usePre) begin
                state <= psp_pkg::PSP_PRE;
                bitCnt <= `PSP_PRE_CNT;
                mdioOut <= 1'b1;
                hdr <= frameHdr;
              end else begin
                // RL13 RL15 preamble dropped: header starts at once
                state <= psp_pkg::PSP_CMD;
                bitCnt <= `PSP_CMD_CNT;
                mdioOut <= frameHdr[13];
                hdr <= {frameHdr[12:0], 1'b0};
              end
            end
          end
          psp_pkg::PSP_PRE: begin
            if (bitCnt == 5'h00) begin
              state <= psp_pkg::PSP_CMD;
              bitCnt <= `PSP_CMD_CNT;
              mdioOut <= hdr[13];
              hdr <= {hdr[12:0], 1'b0};
            end else begin
              bitCnt <= bitCnt - 5'h01;
            end
          end
          psp_pkg::PSP_CMD: begin
            if (bitCnt == 5'h00) begin
              state <= psp_pkg::PSP_TA;
              bitCnt <= `PSP_TA_CNT;
              mdioOe <= 1'b0;
              mdioOut <= 1'b1;
            end else begin
              bitCnt <= bitCnt - 5'h01;
              mdioOut <= hdr[13];
              hdr <= {hdr[12:0], 1'b0};
            end
          end
          psp_pkg::PSP_TA: begin
            if (bitCnt == 5'h00) begin
              state <= psp_pkg::PSP_DATA;
              bitCnt <= `PSP_DATA_CNT;
            end else begin
              bitCnt <= bitCnt - 5'h01;
            end
          end
          psp_pkg::PSP_DATA: begin
            // cell ends: its bit is taken at the next rise
            sampleDue <= 1'b1;
            if (bitCnt == 5'h00) begin
              state <= psp_pkg::PSP_IDLE;
            end else begin
              bitCnt <= bitCnt - 5'h01;
            end
          end
          default: state <= psp_pkg::PSP_IDLE;
        endcase
      end
      // phy answers after a rise; the filter needs half a period to pass it
      if (riseTick && sampleDue) begin
        sampleDue <= 1'b0;
        rxShift <= {rxShift[14:0], mdioVal};
        if (state == psp_pkg::PSP_IDLE) begin
          // last bit in: frame done, gap starts
          doneValid <= 1'b1;
          gapCnt <= 16'(POLL_GAP);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // results and change flags
  logic [1:0] changed; // slots 1 and 2 saw a new value

  // RL11 RL18 change against the last value
  generate
    for (genvar s = 0; s < 2; s++) begin : g_flag
      assign changed[s] = doneValid && globalPhyPollEnable &&
        curSlot == 2'(s + 1) && rxShift != lastValue[s];
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          lastValue[s] <= 16'h0000;
        end else if (doneValid && curSlot == 2'(s + 1)) begin
          lastValue[s] <= rxShift;
        end
      end
    end
  endgenerate

  // change flags: set wins over clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      slot1ChangeFlag <= 1'b0;
      slot2ChangeFlag <= 1'b0;
    end else begin
      slot1ChangeFlag <= changed[0] | (slot1ChangeFlag & ~changeFlagClear[0]);
      slot2ChangeFlag <= changed[1] | (slot2ChangeFlag & ~changeFlagClear[1]);
    end
  end

  // RL1 RL2 RL3 slot 5 result, only the pin clears it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pollResultSlot5 <= 16'h0000;
    end else if (doneValid && curSlot == `PSP_SLOT5) begin
      pollResultSlot5 <= rxShift;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_res_rst_zero: assert property (@(posedge core_clk) $rose(rst_b) |-> pollResultSlot5 == 16'h0000) // RL1
    else $error("slot 5 result not zero after reset");
  a_ee_keeps_res: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ctlDefault && !doneValid) |=> $stable(pollResultSlot5)) // RL2
    else $error("eeprom event changed slot 5 result");
  a_res_update: assert property (@(posedge core_clk) disable iff (!rst_b)
    (doneValid && curSlot == `PSP_SLOT5) |=> pollResultSlot5 == $past(rxShift)) // RL3
    else $error("slot 5 result not updated");
  a_ee_defaults: assert property (@(posedge core_clk) disable iff (!rst_b)
    ctlDefault |=> pollControlSlot0 == `PSP_CTL0_RST && pollControlSlot1 == `PSP_CTL_RST
      && pollControlSlot2 == `PSP_CTL_RST) // RL4
    else $error("control registers not at defaults");
  a_legacy_copy: assert property (@(posedge core_clk) disable iff (!rst_b)
    (eeWr.valid && !ctlDefault && eeWr.addr == `PSP_OFF_CTL0)
      |=> legacyPhyAddr == $past(eeWr.data[`PSP_LEG_HI:`PSP_LEG_LO])) // RL6
    else $error("legacy address not copied");
  a_slot0_fixed: assert property (@(posedge core_clk) disable iff (!rst_b)
    (regReq.rd && regReq.addr == `PSP_OFF_CTL0)
      |=> regRvalid && regRdata[15] && regRdata[12:8] == `PSP_STATUS_REG) // RL7
    else $error("slot 0 fixed fields wrong");
  a_global_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    (frameStart && nextSlot != `PSP_SLOT0) |-> globalPhyPollEnable) // RL20
    else $error("frame for slot 1 to 5 with polling off");
  a_flag1_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    (doneValid && curSlot == `PSP_SLOT1 && globalPhyPollEnable
      && rxShift != lastValue[0]) |=> slot1ChangeFlag) // RL11
    else $error("slot 1 change not flagged");
  a_nopre_slot1: assert property (@(posedge core_clk) disable iff (!rst_b)
    (frameStart && nextSlot == `PSP_SLOT1 && !cfg[1].useDflt && cfg[1].preSup)
      |=> state == psp_pkg::PSP_CMD) // RL13
    else $error("preamble sent although suppressed");
  a_dflt_addr: assert property (@(posedge core_clk) disable iff (!rst_b)
    (frameStart && nextSlot == `PSP_SLOT1 && cfg[1].useDflt)
      |-> tgtPhy == defaultPhyAddress) // RL14
    else $error("default phy address not used");
  a_ta_release: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state == psp_pkg::PSP_TA || state == psp_pkg::PSP_DATA) |-> !mdioOe) // RL19
    else $error("mdio driven during read phase");
  c_slot5_done: cover property (@(posedge core_clk) doneValid && curSlot == `PSP_SLOT5);
  c_flag2_set: cover property (@(posedge core_clk) $rose(slot2ChangeFlag));
  c_nopre_frame: cover property (@(posedge core_clk) frameStart && !usePre);
  c_ee_legacy: cover property (@(posedge core_clk) eeWr.valid && eeWr.addr == `PSP_OFF_CTL0);

endmodule
`default_nettype wire

// >>> psp_phy_model.sv
// Purpose: behavioural phy answering management read frames
// Assumes: station cells read on mdc rise, pull-up on the line
// Notes: slow gives a late but legal answer
`timescale 1ns/1ps
`default_nettype none
module psp_phy_model (
  input wire logic mdc,
  input wire logic mdioOut,
  input wire logic mdioOe,
  input wire logic slow,
  output logic phyOut,
  output logic phyOe
);
  logic [15:0] regVal [0:31][0:31]; // contents by address, number
  logic [13:0] hdr; // last station cells
  logic [15:0] word; // word being returned
  logic [4:0] lastPhy; // address of last frame
  logic [4:0] lastReg; // number of last frame
  int nOe; // cells driven by station
  int lastPre; // preamble cells of last frame
  int frameCount; // frames answered
  int dly; // answer delay after mdc rises
  ////////////////////////////////////////
  // power-up contents, line released
  initial begin
    phyOut = 1'b1;
    phyOe = 1'b0;
    frameCount = 0;
    nOe = 0;
    hdr = '0;
    for (int p = 0; p < 32; p++) begin
      for (int r = 0; r < 32; r++) begin
        regVal[p][r] = 16'h0000;
      end
    end
  end
  always begin
    @(posedge mdc);
    if (mdioOe) begin
      hdr = {hdr[12:0], mdioOut};
      nOe = nOe + 1;
    end else if (nOe >= 14 && hdr[13:10] == 4'b0110) begin
      // start and read code seen: answer it
      lastPhy = hdr[9:5];
      lastReg = hdr[4:0];
      lastPre = nOe - 14;
      nOe = 0;
      word = regVal[lastPhy][lastReg];
      dly = slow ? 200 : 20;
      @(posedge mdc);
      #(dly);
      phyOe = 1'b1;
      phyOut = 1'b0;
      for (int i = 15; i >= 0; i--) begin
        @(posedge mdc);
        #(dly);
        phyOut = word[i];
      end
      // hold the last bit past the station's sampling rise, then release
      @(posedge mdc);
      #(dly);
      phyOe = 1'b0;
      phyOut = ~phyOut;
      frameCount = frameCount + 1;
    end else begin
      nOe = 0;
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
// Purpose: self-checking bench for the phy status poller
// Assumes: short poll gap, phy model on the management link
// Notes: prints only mismatches and the verdict
`include "psp_poll_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk; // core clock
  logic rst_b; // hardware reset, active low
  psp_pkg::psp_reg_req_t regReq; // host request
  psp_pkg::psp_ee_wr_t eeWr; // eeprom beat
  logic [15:0] regRdata;
  logic [4:0] legacyPhyAddr, polledPhyRegisterSlot5;
  logic [1:0] changeFlagClear;
  logic regRvalid, eeStart, eeFail, globalPhyPollEnable, defaultPhyNoPreamble;
  logic slot5PollEnable, slot1ChangeFlag, slot2ChangeFlag;
  logic mdc, mdioOut, mdioOe, phyOut, phyOe, slow;
  wire logic mdioIn; // resolved line, pull-up when idle
  int nFail, checkCount;
  int cycles = 0;
  assign mdioIn = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);
  psp_poller #(.POLL_GAP(20)) dut (.core_clk(core_clk), .rst_b(rst_b), .regReq(regReq),
    .regRdata(regRdata), .regRvalid(regRvalid), .eeStart(eeStart), .eeFail(eeFail),
    .eeWr(eeWr), .legacyPhyAddr(legacyPhyAddr), .globalPhyPollEnable(globalPhyPollEnable),
    .defaultPhyNoPreamble(defaultPhyNoPreamble), .slot5PollEnable(slot5PollEnable),
    .polledPhyRegisterSlot5(polledPhyRegisterSlot5), .changeFlagClear(changeFlagClear),
    .slot1ChangeFlag(slot1ChangeFlag), .slot2ChangeFlag(slot2ChangeFlag), .mdc(mdc),
    .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe));
  psp_phy_model phy (.mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe), .slow(slow),
    .phyOut(phyOut), .phyOe(phyOe));
  ////////////////////////////////////////
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      nFail = nFail + 1;
      printVerdict();
    end
  end
  ////////////////////////////////////////
  // shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checkCount = checkCount + 1;
    if (got !== exp) begin
      nFail = nFail + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    regReq.wr = 1'b1;
    regReq.addr = a;
    regReq.data = d;
    @(negedge core_clk);
    regReq.wr = 1'b0;
  endtask
  // read data counts only while valid
  task automatic readCheck(input logic [7:0] a, input logic [15:0] exp);
    @(negedge core_clk);
    regReq.rd = 1'b1;
    regReq.addr = a;
    @(negedge core_clk);
    regReq.rd = 1'b0;
    check((regRvalid === 1'b1) ? regRdata : ~exp, exp);
  endtask
  task automatic eeBeat(input logic s, input logic f, input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    eeStart = s;
    eeFail = f;
    eeWr.valid = !(s || f);
    eeWr.addr = a;
    eeWr.data = d;
    @(negedge core_clk);
    {eeStart, eeFail, eeWr.valid} = 3'b000;
  endtask
  task automatic clearFlags();
    @(negedge core_clk);
    changeFlagClear = 2'h3;
    @(negedge core_clk);
    changeFlagClear = 2'h0;
  endtask
  // one answered frame, then time for result update
  task automatic nextFrame();
    int n0;
    n0 = phy.frameCount;
    wait (phy.frameCount != n0);
    repeat (6) @(negedge core_clk);
  endtask
  task automatic findFrame(input logic [4:0] p, input logic [4:0] r, input int pre);
    bit hit;
    hit = 1'b0;
    for (int k = 0; k < 8 && !hit; k++) begin
      nextFrame();
      hit = (phy.lastPhy === p) && (phy.lastReg === r);
    end
    check({15'h0000, hit}, 16'h0001);
    check(16'(phy.lastPre), 16'(pre));
  endtask
  task automatic printVerdict();
    if (nFail == 0 && checkCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // scenarios
  task automatic testResetValues();
    readCheck(`PSP_OFF_CTL0, 16'h8100);
    readCheck(`PSP_OFF_CTL1, 16'h0000);
    readCheck(`PSP_OFF_CTL2, 16'h0000);
    readCheck(`PSP_OFF_RES5, 16'h0000);
    readCheck(8'h90, 16'h0000);
  endtask
  task automatic testSlot0Fields();
    regWrite(`PSP_OFF_CTL0, 16'h000A);
    readCheck(`PSP_OFF_CTL0, 16'h810A);
    regWrite(`PSP_OFF_RES5, 16'h5555);
    readCheck(`PSP_OFF_RES5, 16'h0000);
    regWrite(`PSP_OFF_CTL1, 16'h8347);
    readCheck(`PSP_OFF_CTL1, 16'h8347);
  endtask
  task automatic testEeprom();
    eeBeat(1'b0, 1'b0, `PSP_OFF_CTL0, 16'h03E5);
    check({11'h000, legacyPhyAddr}, 16'h001F);
    readCheck(`PSP_OFF_CTL0, 16'h8105);
    eeBeat(1'b1, 1'b0, 8'h00, 16'h0000);
    readCheck(`PSP_OFF_CTL0, 16'h8100);
    readCheck(`PSP_OFF_CTL1, 16'h0000);
    regWrite(`PSP_OFF_CTL2, 16'h8405);
    eeBeat(1'b0, 1'b1, 8'h00, 16'h0000);
    readCheck(`PSP_OFF_CTL2, 16'h0000);
  endtask
  task automatic testPolling();
    phy.regVal[7][3] = 16'hBEEF;
    phy.regVal[10][9] = 16'hC0DE;
    regWrite(`PSP_OFF_CTL0, 16'h000A);
    regWrite(`PSP_OFF_CTL1, 16'h8347);
    slot5PollEnable = 1'b1;
    polledPhyRegisterSlot5 = 5'h09;
    globalPhyPollEnable = 1'b1;
    findFrame(5'h0A, 5'h01, 32);
    findFrame(5'h07, 5'h03, 0);
    check({15'h0000, slot1ChangeFlag}, 16'h0001);
    findFrame(5'h0A, 5'h09, 32);
    readCheck(`PSP_OFF_RES5, 16'hC0DE);
    slow = 1'b1;
    phy.regVal[10][9] = 16'h0F0F;
    findFrame(5'h0A, 5'h09, 32);
    readCheck(`PSP_OFF_RES5, 16'h0F0F);
    slow = 1'b0;
  endtask
  task automatic testDefaultPhy();
    regWrite(`PSP_OFF_CTL1, 16'h8363);
    defaultPhyNoPreamble = 1'b1;
    findFrame(5'h0A, 5'h03, 0);
    defaultPhyNoPreamble = 1'b0;
    findFrame(5'h0A, 5'h03, 32);
  endtask
  task automatic testSlot2();
    phy.regVal[5][4] = 16'h0001;
    regWrite(`PSP_OFF_CTL2, 16'h8405);
    clearFlags();
    findFrame(5'h05, 5'h04, 32);
    check({15'h0000, slot2ChangeFlag}, 16'h0001);
  endtask
  task automatic testGlobalOff();
    globalPhyPollEnable = 1'b0;
    nextFrame();
    clearFlags();
    phy.regVal[5][4] = 16'h0002;
    phy.regVal[10][9] = 16'h1111;
    phy.regVal[10][3] = 16'h2222;
    repeat (3) begin
      nextFrame();
      check({11'h000, phy.lastReg}, 16'h0001);
    end
    check({14'h0000, slot2ChangeFlag, slot1ChangeFlag}, 16'h0000);
    readCheck(`PSP_OFF_RES5, 16'h0F0F);
  endtask
  task automatic testResultKeep();
    eeBeat(1'b1, 1'b0, 8'h00, 16'h0000);
    readCheck(`PSP_OFF_RES5, 16'h0F0F);
    eeBeat(1'b0, 1'b1, 8'h00, 16'h0000);
    readCheck(`PSP_OFF_RES5, 16'h0F0F);
  endtask
  task automatic testHwReset();
    regWrite(`PSP_OFF_CTL1, 16'h8347);
    @(negedge core_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    readCheck(`PSP_OFF_RES5, 16'h0000);
    readCheck(`PSP_OFF_CTL1, 16'h0000);
    readCheck(`PSP_OFF_CTL0, 16'h8100);
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    nFail = 0;
    checkCount = 0;
    rst_b = 1'b0;
    regReq = '0;
    eeWr = '0;
    {eeStart, eeFail, globalPhyPollEnable, defaultPhyNoPreamble} = 4'h0;
    {slot5PollEnable, slow} = 2'b00;
    polledPhyRegisterSlot5 = 5'h00;
    changeFlagClear = 2'h0;
    repeat (4) @(negedge core_clk);
    rst_b = 1'b1;
    testResetValues();
    testSlot0Fields();
    testEeprom();
    testPolling();
    testDefaultPhy();
    testSlot2();
    testGlobalOff();
    testResultKeep();
    testHwReset();
    printVerdict();
  end
endmodule
`default_nettype wire
